// ### verilog/tm8_pkg.sv
// Constants, field layouts and types shared by the 8-bit timer with one compare unit
// Function
// - Counter and compare value are 8-bit; comparator uses all eight bits.
// - Count 0x00 is bottom, 0xFF is maximum; both feed waveform logic.
// - Highest count is fixed maximum or compare value, chosen by mode.
// - Counter ticks from prescaled clock or external pin, chosen by clock select.
// - Clock select zero stops the counter; no count and no clear happen.
// - Each tick clears, increments or decrements by one as the mode dictates.
// - Software reads and writes the counter any time, even when stopped.
// - A software counter write beats any clear or count in that cycle.
// - Overflow flag sets at the mode's point and can request an interrupt.
// - Counter equal to active compare sets compare flag on that tick.
// - Compare interrupt needs flag, its enable bit and global enable.
// - Compare flag clears when serviced or when software writes one to it.
// - Every request shows in the flag register whatever its mask bit; the mask gates only the interrupt.
// - Output follows match, mode and output action, with max and bottom cases.
// - PWM modes buffer compare value, loading at top or bottom; others don't.
// - Compare access goes to buffer when buffering, else to active register.
// - Force strobe in non-PWM modes acts like a match without flag or clear.
// - Counter write blocks the compare match on the next tick, even stopped.
// - Compare output register keeps its value across mode changes.
// - Output action bits take effect at once, not buffered with compare.
// - Mode 0 counts up, wraps without clear, sets overflow when reaching zero.
// - Mode 2 clears the counter on the tick that matches the compare value.
// - Mode 3 counts bottom to max; non-inverting clears on match, sets at bottom.
// - Output action zero leaves the compare output untouched in every mode.
package tm8_pkg;

  // ==========================================================================
  // Register byte offsets on APB
  localparam logic [7:0] TM8_OFS_CTRL    = 8'h00;
  localparam logic [7:0] TM8_OFS_COUNT   = 8'h04;
  localparam logic [7:0] TM8_OFS_COMPARE = 8'h08;
  localparam logic [7:0] TM8_OFS_FLAGS   = 8'h0c;
  localparam logic [7:0] TM8_OFS_MASK    = 8'h10;
  localparam logic [7:0] TM8_OFS_STATUS  = 8'h14;

  // ==========================================================================
  // Count extremes and reset values
  localparam logic [7:0] TM8_BOTTOM    = 8'h00;
  localparam logic [7:0] TM8_MAX       = 8'hff;
  localparam logic [7:0] TM8_RST_BYTE  = 8'h00;
  localparam logic [7:0] TM8_ONE       = 8'h01;

  // Prescaler taps: a tick when the masked low bits are all ones
  localparam logic [9:0] TM8_PRE8_MASK    = 10'h007;
  localparam logic [9:0] TM8_PRE64_MASK   = 10'h03f;
  localparam logic [9:0] TM8_PRE256_MASK  = 10'h0ff;
  localparam logic [9:0] TM8_PRE1024_MASK = 10'h3ff;

  // ==========================================================================
  // Clock select encodings
  localparam logic [2:0] TM8_CS_STOP    = 3'h0;
  localparam logic [2:0] TM8_CS_DIV1    = 3'h1;
  localparam logic [2:0] TM8_CS_DIV8    = 3'h2;
  localparam logic [2:0] TM8_CS_DIV64   = 3'h3;
  localparam logic [2:0] TM8_CS_DIV256  = 3'h4;
  localparam logic [2:0] TM8_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TM8_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TM8_CS_EXT_RISE = 3'h7;

  // Waveform modes
  typedef enum logic [1:0] {
    TM8_WM_NORMAL = 2'h0,
    TM8_WM_PHASE  = 2'h1,
    TM8_WM_CTC    = 2'h2,
    TM8_WM_FAST   = 2'h3
  } tm8_wave_t;

  // Output action modes
  localparam logic [1:0] TM8_OA_NONE   = 2'h0;
  localparam logic [1:0] TM8_OA_TOGGLE = 2'h1;
  localparam logic [1:0] TM8_OA_CLEAR  = 2'h2;
  localparam logic [1:0] TM8_OA_SET    = 2'h3;

  // Count direction, a one-bit Gray sequence
  typedef enum logic {
    TM8_DIR_UP   = 1'b0,
    TM8_DIR_DOWN = 1'b1
  } tm8_dir_t;

  // Control register layout, high bit first: strobe is bit 7, clock select bits 2 to 0
  typedef struct packed {
    logic       force_compare_strobe;
    logic [1:0] output_action_mode;
    tm8_wave_t  wave_mode;
    logic [2:0] clock_select;
  } tm8_ctrl_t;

  // Flag and mask layout: bit 0 overflow, bit 1 compare
  typedef struct packed {
    logic compare;
    logic overflow;
  } tm8_irq_bits_t;

  localparam logic [1:0] TM8_IRQ_RST = 2'h0;

endpackage

// ### verilog/tm8_timer.sv
// APB-mapped 8-bit timer/counter with one compare unit and waveform output
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps

module tm8_timer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_event_pin,
  input  wire logic        global_irq_enable,
  input  wire logic        overflow_irq_ack,
  input  wire logic        compare_irq_ack,
  output logic             overflow_irq,
  output logic             compare_irq,
  output logic             compare_output
);

  // ==========================================================================
  // State
  tm8_pkg::tm8_ctrl_t     ctrl;
  tm8_pkg::tm8_ctrl_t     next_ctrl;
  tm8_pkg::tm8_irq_bits_t flags;
  tm8_pkg::tm8_irq_bits_t next_flags;
  tm8_pkg::tm8_irq_bits_t mask;
  tm8_pkg::tm8_irq_bits_t next_mask;
  tm8_pkg::tm8_dir_t      dir;
  tm8_pkg::tm8_dir_t      next_dir;
  logic [7:0]             count_value;
  logic [7:0]             next_count_value;
  logic [7:0]             compare_value;
  logic [7:0]             next_compare_value;
  logic [7:0]             compare_buf;
  logic [7:0]             next_compare_buf;
  logic                   block_match;
  logic                   next_block_match;
  logic                   next_compare_output;
  logic [9:0]             presc;
  logic                   ext_s1;
  logic                   ext_s2;
  logic                   ext_s3;
  logic [31:0]            next_prdata;
  logic                   next_pready;
  logic                   next_pslverr;
  logic                   next_overflow_irq;
  logic                   next_compare_irq;

  // Decoded bus strobes and timer conditions
  logic       access;
  logic       wr_done;
  logic       mapped;
  logic       ctrl_wr;
  logic       count_wr;
  logic       compare_wr;
  logic       flags_wr;
  logic       mask_wr;
  logic       timer_tick;
  logic       is_pwm;
  logic       at_max;
  logic       at_bottom;
  logic       raw_equal;
  logic       match;
  logic       force_hit;
  tm8_pkg::tm8_ctrl_t wr_ctrl;

  // ==========================================================================
  // APB slave: one wait state, answer registered
  assign access  = psel & penable;
  assign wr_done = access & pready & pwrite;
  assign mapped  = (paddr == tm8_pkg::TM8_OFS_CTRL)    | (paddr == tm8_pkg::TM8_OFS_COUNT) |
                   (paddr == tm8_pkg::TM8_OFS_COMPARE) | (paddr == tm8_pkg::TM8_OFS_FLAGS) |
                   (paddr == tm8_pkg::TM8_OFS_MASK)    | (paddr == tm8_pkg::TM8_OFS_STATUS);
  assign ctrl_wr    = wr_done & (paddr == tm8_pkg::TM8_OFS_CTRL);
  assign count_wr   = wr_done & (paddr == tm8_pkg::TM8_OFS_COUNT);
  assign compare_wr = wr_done & (paddr == tm8_pkg::TM8_OFS_COMPARE);
  assign flags_wr   = wr_done & (paddr == tm8_pkg::TM8_OFS_FLAGS);
  assign mask_wr    = wr_done & (paddr == tm8_pkg::TM8_OFS_MASK);

  // Read mux; force strobe always reads back as zero
  always_comb begin
    next_pready  = access & ~pready;
    next_pslverr = access & ~pready & ~mapped;
    next_prdata  = 32'h0000_0000;
    if (access & ~pready & ~pwrite) begin
      case (paddr)
        tm8_pkg::TM8_OFS_CTRL:    next_prdata[6:0] = ctrl[6:0];
        tm8_pkg::TM8_OFS_COUNT:   next_prdata[7:0] = count_value;
        tm8_pkg::TM8_OFS_COMPARE: next_prdata[7:0] = is_pwm ? compare_buf
                                                            : compare_value;
        tm8_pkg::TM8_OFS_FLAGS:   next_prdata[1:0] = flags;
        tm8_pkg::TM8_OFS_MASK:    next_prdata[1:0] = mask;
        tm8_pkg::TM8_OFS_STATUS:  next_prdata[1:0] = {dir, compare_output};
        default:                  next_prdata      = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ==========================================================================
  // Timer clock: prescaler taps or synchronised external pin edges
  // The pin passes two flops before the edge detector sees it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc  <= 10'h000;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      presc  <= presc + 10'h001;
      ext_s1 <= external_event_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // One enable per selected source and edge; stopped when select is zero
  always_comb begin
    case (ctrl.clock_select)
      tm8_pkg::TM8_CS_STOP:     timer_tick = 1'b0;
      tm8_pkg::TM8_CS_DIV1:     timer_tick = 1'b1;
      tm8_pkg::TM8_CS_DIV8:     timer_tick = (presc & tm8_pkg::TM8_PRE8_MASK)
                                             == tm8_pkg::TM8_PRE8_MASK;
      tm8_pkg::TM8_CS_DIV64:    timer_tick = (presc & tm8_pkg::TM8_PRE64_MASK)
                                             == tm8_pkg::TM8_PRE64_MASK;
      tm8_pkg::TM8_CS_DIV256:   timer_tick = (presc & tm8_pkg::TM8_PRE256_MASK)
                                             == tm8_pkg::TM8_PRE256_MASK;
      tm8_pkg::TM8_CS_DIV1024:  timer_tick = presc == tm8_pkg::TM8_PRE1024_MASK;
      tm8_pkg::TM8_CS_EXT_FALL: timer_tick = ext_s3 & ~ext_s2;
      tm8_pkg::TM8_CS_EXT_RISE: timer_tick = ~ext_s3 & ext_s2;
      default:                  timer_tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // Comparator and extreme-value detection
  assign is_pwm    = (ctrl.wave_mode == tm8_pkg::TM8_WM_PHASE) |
                     (ctrl.wave_mode == tm8_pkg::TM8_WM_FAST);
  assign at_max    = count_value == tm8_pkg::TM8_MAX;
  assign at_bottom = count_value == tm8_pkg::TM8_BOTTOM;
  assign raw_equal = count_value == compare_value;
  assign match     = raw_equal & ~block_match;
  assign wr_ctrl   = tm8_pkg::tm8_ctrl_t'(pwdata[7:0]);
  assign force_hit = ctrl_wr & wr_ctrl.force_compare_strobe & ~is_pwm;

  // Counter, buffer, flags and output; software writes other than flag clears are applied last so they win
  always_comb begin
    next_ctrl           = ctrl;
    next_mask           = mask;
    next_dir            = dir;
    next_count_value    = count_value;
    next_compare_value  = compare_value;
    next_compare_buf    = compare_buf;
    next_block_match    = block_match;
    next_compare_output = compare_output;
    next_flags          = flags;
    // Clears first, so a set in the same cycle survives
    if (flags_wr) begin
      next_flags = next_flags & ~tm8_pkg::tm8_irq_bits_t'(pwdata[1:0]);
    end
    if (compare_irq_ack) begin
      next_flags.compare = 1'b0;
    end
    if (overflow_irq_ack) begin
      next_flags.overflow = 1'b0;
    end
    if (timer_tick) begin
      next_block_match = 1'b0;
      if (match) begin
        next_flags.compare = 1'b1;
      end
      case (ctrl.wave_mode)
        tm8_pkg::TM8_WM_NORMAL: begin
          next_count_value = count_value + tm8_pkg::TM8_ONE;
          if (at_max) begin
            next_flags.overflow = 1'b1;
          end
          if (match) begin
            case (ctrl.output_action_mode)
              tm8_pkg::TM8_OA_TOGGLE: next_compare_output = ~compare_output;
              tm8_pkg::TM8_OA_CLEAR:  next_compare_output = 1'b0;
              tm8_pkg::TM8_OA_SET:    next_compare_output = 1'b1;
              default:                next_compare_output = compare_output;
            endcase
          end
        end
        tm8_pkg::TM8_WM_CTC: begin
          // Compare value acts as top: the matching tick reloads zero
          next_count_value = match ? tm8_pkg::TM8_BOTTOM
                                   : count_value + tm8_pkg::TM8_ONE;
          if (at_max) begin
            next_flags.overflow = 1'b1;
          end
          if (match) begin
            case (ctrl.output_action_mode)
              tm8_pkg::TM8_OA_TOGGLE: next_compare_output = ~compare_output;
              tm8_pkg::TM8_OA_CLEAR:  next_compare_output = 1'b0;
              tm8_pkg::TM8_OA_SET:    next_compare_output = 1'b1;
              default:                next_compare_output = compare_output;
            endcase
          end
        end
        tm8_pkg::TM8_WM_FAST: begin
          next_count_value = count_value + tm8_pkg::TM8_ONE;
          if (at_max) begin
            next_flags.overflow = 1'b1;
            next_compare_value  = compare_buf;
          end
          // Match first, bottom last: a compare of max then gives a steady level
          if (match & ctrl.output_action_mode[1]) begin
            next_compare_output = ctrl.output_action_mode[0];
          end
          if (at_max & ctrl.output_action_mode[1]) begin
            next_compare_output = ~ctrl.output_action_mode[0];
          end
        end
        tm8_pkg::TM8_WM_PHASE: begin
          if (dir == tm8_pkg::TM8_DIR_UP) begin
            if (at_max) begin
              next_dir           = tm8_pkg::TM8_DIR_DOWN;
              next_count_value   = count_value - tm8_pkg::TM8_ONE;
              next_compare_value = compare_buf;
            end else begin
              next_count_value = count_value + tm8_pkg::TM8_ONE;
            end
          end else begin
            if (at_bottom) begin
              next_dir            = tm8_pkg::TM8_DIR_UP;
              next_count_value    = count_value + tm8_pkg::TM8_ONE;
              next_flags.overflow = 1'b1;
            end else begin
              next_count_value = count_value - tm8_pkg::TM8_ONE;
            end
          end
          // Non-inverting clears on the way up, sets on the way down
          if (match & ctrl.output_action_mode[1]) begin
            next_compare_output = (dir == tm8_pkg::TM8_DIR_DOWN) ^
                                  ctrl.output_action_mode[0];
          end
        end
        default: next_count_value = count_value;
      endcase
    end
    // Forced compare: output only, no flag and no counter change
    // Action bits written with the strobe apply, since they take effect at once
    if (force_hit) begin
      case (wr_ctrl.output_action_mode)
        tm8_pkg::TM8_OA_TOGGLE: next_compare_output = ~compare_output;
        tm8_pkg::TM8_OA_CLEAR:  next_compare_output = 1'b0;
        tm8_pkg::TM8_OA_SET:    next_compare_output = 1'b1;
        default:                next_compare_output = compare_output;
      endcase
    end
    // Control takes effect at once; the strobe bit is never stored
    if (ctrl_wr) begin
      next_ctrl = tm8_pkg::tm8_ctrl_t'({1'b0, pwdata[6:0]});
    end
    if (mask_wr) begin
      next_mask = tm8_pkg::tm8_irq_bits_t'(pwdata[1:0]);
    end
    if (compare_wr) begin
      next_compare_buf = pwdata[7:0];
      if (!is_pwm) begin
        next_compare_value = pwdata[7:0];
      end
    end
    if (count_wr) begin
      next_count_value = pwdata[7:0];
      next_block_match = 1'b1;
    end
  end

  // Interrupt requests: flag gated by its mask bit and the global enable
  assign next_overflow_irq = flags.overflow & mask.overflow & global_irq_enable;
  assign next_compare_irq  = flags.compare & mask.compare & global_irq_enable;

  // Timer state registers; all clear on reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl           <= tm8_pkg::tm8_ctrl_t'(tm8_pkg::TM8_RST_BYTE);
      mask           <= tm8_pkg::tm8_irq_bits_t'(tm8_pkg::TM8_IRQ_RST);
      flags          <= tm8_pkg::tm8_irq_bits_t'(tm8_pkg::TM8_IRQ_RST);
      dir            <= tm8_pkg::TM8_DIR_UP;
      count_value    <= tm8_pkg::TM8_RST_BYTE;
      compare_value  <= tm8_pkg::TM8_RST_BYTE;
      compare_buf    <= tm8_pkg::TM8_RST_BYTE;
      block_match    <= 1'b0;
      compare_output <= 1'b0;
      overflow_irq   <= 1'b0;
      compare_irq    <= 1'b0;
    end else begin
      ctrl           <= next_ctrl;
      mask           <= next_mask;
      flags          <= next_flags;
      dir            <= next_dir;
      count_value    <= next_count_value;
      compare_value  <= next_compare_value;
      compare_buf    <= next_compare_buf;
      block_match    <= next_block_match;
      compare_output <= next_compare_output;
      overflow_irq   <= next_overflow_irq;
      compare_irq    <= next_compare_irq;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_count_write;
    count_wr;
  endsequence

  sequence s_blocked_tick;
    timer_tick && block_match && !flags.compare && !count_wr;
  endsequence

  property p_stopped;
    (ctrl.clock_select == tm8_pkg::TM8_CS_STOP) && !count_wr |=>
      count_value == $past(count_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_write_wins;
    s_count_write |=> count_value == $past(pwdata[7:0]) && block_match;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost");

  property p_normal_wrap;
    timer_tick && (ctrl.wave_mode == tm8_pkg::TM8_WM_NORMAL) && at_max && !count_wr |=>
      at_bottom && flags.overflow;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

  property p_ctc_clear;
    timer_tick && (ctrl.wave_mode == tm8_pkg::TM8_WM_CTC) && match && !count_wr |=>
      at_bottom;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on compare");

  property p_compare_flag;
    timer_tick && raw_equal && !block_match |=> flags.compare;
  endproperty
  a_compare_flag: assert property (p_compare_flag) else $error("compare flag missed");

  property p_block;
    s_blocked_tick ##0 !flags_wr ##1 !ctrl_wr |-> !flags.compare;
  endproperty
  a_block: assert property (p_block) else $error("blocked match set flag");

  property p_irq;
    flags.compare && mask.compare && global_irq_enable |=> compare_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("compare request missing");

  property p_force;
    force_hit && (pwdata[6:5] == tm8_pkg::TM8_OA_SET) && !timer_tick |=>
      compare_output && count_value == $past(count_value) &&
      flags.compare == ($past(flags.compare) & !$past(compare_irq_ack));
  endproperty
  a_force: assert property (p_force) else $error("force compare wrong");

  property p_buffered;
    is_pwm && !timer_tick && !ctrl_wr |=> compare_value == $past(compare_value);
  endproperty
  a_buffered: assert property (p_buffered) else $error("compare loaded mid period");

  property p_fast_bottom;
    timer_tick && (ctrl.wave_mode == tm8_pkg::TM8_WM_FAST) && at_max && !force_hit &&
      (ctrl.output_action_mode == tm8_pkg::TM8_OA_CLEAR) |=> compare_output;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast pwm not set at bottom");

endmodule // tm8_timer

// ### testbench/tm8_timer_tb.sv
// Self-checking bench for the APB-mapped 8-bit timer
`timescale 1ns/1ps

module tm8_timer_tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        gie = 1'b0;
  logic        ov_ack = 1'b0;
  logic        cmp_ack = 1'b0;
  logic        ev = 1'b0;
  logic        compare_irq;
  logic        ov_irq;
  logic [31:0] r;
  logic        er;
  int          num_errors = 0;
  int          n_checks = 0;

  tm8_timer dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_event_pin(ev), .global_irq_enable(gie),
    .overflow_irq_ack(ov_ack), .compare_irq_ack(cmp_ack), .overflow_irq(ov_irq),
    .compare_irq(compare_irq), .compare_output());

  // ==========================================================
  // Clock, bus tasks and comparison
  initial begin
    forever #2 clk = ~clk;
  end

  // Ready is sampled at the rising edge; the request stands until that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge clk);
    end
    if (k >= 20) begin
      num_errors++;
      $display("unexpected pready expected 1 seen 0");
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pin edges held long enough for the synchroniser to pass each one
  task automatic pulse(input int n);
    repeat (n) begin
      ev <= 1'b1;
      repeat (4) @(posedge clk);
      ev <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), e, r);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b1, 8'h04, 32'h10);
    rd(8'h04, 32'h10);
    repeat (20) @(posedge clk);
    rd(8'h04, 32'h10);
    apb(1'b1, 8'h08, 32'h10);
    apb(1'b1, 8'h00, 32'ha0);
    rd(8'h14, 32'h1);
    rd(8'h0c, 32'h0);
    rd(8'h00, 32'h20);
    apb(1'b1, 8'h00, 32'h38);
    rd(8'h14, 32'h1);
    apb(1'b1, 8'h08, 32'h40);
    rd(8'h08, 32'h40);
    // Normal mode from a count equal to compare: first match is blocked
    apb(1'b1, 8'h10, 32'h3);
    gie <= 1'b1;
    apb(1'b1, 8'h00, 32'h01);
    repeat (300) @(posedge clk);
    rd(8'h0c, 32'h3);
    chk("compare_irq", 32'h1, {31'h0, compare_irq});
    chk("overflow_irq", 32'h1, {31'h0, ov_irq});
    gie <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq_gated", 32'h0, {31'h0, compare_irq});
    chk("ov_irq_gated", 32'h0, {31'h0, ov_irq});
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h0c, 32'h2);
    rd(8'h0c, 32'h1);
    ov_ack <= 1'b1;
    @(posedge clk);
    ov_ack <= 1'b0;
    rd(8'h0c, 32'h0);
    // Clear on match keeps the count at or below compare
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b1, 8'h00, 32'h11);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'h04, 32'h0);
      chk("ctc_count", 32'h1, {31'h0, r <= 32'h5});
    end
    apb(1'b1, 8'h00, 32'h00);
    rd(8'h0c, 32'h2);
    cmp_ack <= 1'b1;
    @(posedge clk);
    cmp_ack <= 1'b0;
    rd(8'h0c, 32'h0);
    // External rising edges clock the counter
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h07);
    pulse(3);
    rd(8'h04, 32'h3);
    // Phase correct: up to max, then down; buffer loads at the top
    apb(1'b1, 8'h00, 32'h4f);
    apb(1'b1, 8'h08, 32'h40);
    rd(8'h08, 32'h40);
    apb(1'b1, 8'h04, 32'hfe);
    pulse(3);
    rd(8'h04, 32'hfd);
    rd(8'h14, 32'h3);
    apb(1'b1, 8'h00, 32'h00);
    rd(8'h08, 32'h40);
    apb(1'b1, 8'h00, 32'he0);
    rd(8'h14, 32'h3);
    apb(1'b1, 8'h00, 32'hc0);
    rd(8'h14, 32'h2);
    // Fast PWM non-inverting: output set when the count leaves max
    apb(1'b1, 8'h04, 32'hfe);
    apb(1'b1, 8'h00, 32'h5f);
    pulse(2);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h3);
    rd(8'h0c, 32'h1);
    results();
  end
endmodule // tm8_timer_tb
